// *** rtl/dasm_consts.svh ***
`ifndef DASM_CONSTS_SVH
`define DASM_CONSTS_SVH
// Timing
`define DASM_CLK_HZ            20000000
`define DASM_HOLD_MS           1000
`define DASM_HOLD_CYCLES       ((`DASM_CLK_HZ / 1000) * `DASM_HOLD_MS)
// Power-on monitor selection
`define DASM_PON_SEL_RESET     12'hfff
`define DASM_PON_SEL_STATUS    12'hfff
`define DASM_SAFETY_ITEM       12'h015
// Stop selection encodings
`define DASM_G2_SAME_AS_G1     2'h1
// Register map (byte addresses, word index in bits [3:2])
`define DASM_REG_CTRL          4'h0
`define DASM_REG_PARAM         4'h4
`define DASM_REG_STATUS        4'h8
`define DASM_REG_DISP          4'hc
// Control register fields
`define DASM_CTRL_RESET_BIT    0
`define DASM_CTRL_FORCE_BIT    1
// Alarm sources (bit positions of alarmCause)
`define DASM_AL_PARAM_CORRUPT  0
`define DASM_AL_MAIN_DETECT    1
`define DASM_AL_PARAM_RANGE    2
`define DASM_AL_ENC_OUT        3
`define DASM_AL_PARAM_COMBO    4
`define DASM_AL_CAPACITY       5
`define DASM_AL_UNSUPPORTED    6
`define DASM_AL_SCALE_PITCH    7
`define DASM_AL_SERVO_ON       8
`define DASM_AL_OVERCURRENT    9
`define DASM_NUM_ALARMS        10
// Alarm code line patterns {a,b,c}
`define DASM_CODE_ALL_HIGH     3'h7
`define DASM_CODE_OVERCURRENT  3'h3
`define DASM_CODE_NONE         3'h0
// Seven-segment bits {g,f,e,d,c,b,a}
`define DASM_SEG_TOP           7'h01
`define DASM_SEG_BOTTOM        7'h08
`define DASM_SEG_BLANK         7'h00
`endif

// *** rtl/dasm_pkg.sv ***
package dasm_pkg;
  typedef enum logic [1:0] {
    DASM_DISP_STATUS = 2'b00,
    DASM_DISP_ITEM   = 2'b01,
    DASM_DISP_SAFETY = 2'b10
  } dasm_disp_type;
  typedef enum logic [1:0] {
    DASM_STOP_NONE = 2'b00,
    DASM_STOP_G1   = 2'b01,
    DASM_STOP_G2   = 2'b10
  } dasm_stop_type;
endpackage

// *** rtl/dasm_monitor.sv ***
`timescale 1ns/1ps
`include "dasm_consts.svh"
module dasm_monitor #(
  parameter int HOLD_CYCLES = `DASM_HOLD_CYCLES
) (
  input  wire logic                            mclk,
  input  wire logic                            srst,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [3:0]                      avs_address,
  input  wire logic [31:0]                     avs_writedata,
  output logic [31:0]                          avs_readdata,
  output logic                                 avs_waitrequest,
  input  wire logic                            dataShiftKey,
  input  wire logic                            safetyBlockInputOne,
  input  wire logic                            safetyBlockInputTwo,
  input  wire logic                            servoOnRequest,
  input  wire logic                            alarmResetRequest,
  input  wire logic                            utilityEnergized,
  input  wire logic [`DASM_NUM_ALARMS-1:0]     alarmCause,
  input  wire logic                            scalePitchDefault,
  output dasm_pkg::dasm_disp_type              displayMode,
  output logic [11:0]                          displayItem,
  output logic [55:0]                          segments,
  output dasm_pkg::dasm_stop_type              stopGroup,
  output logic [1:0]                           stopMethod,
  output logic                                 alarmActive,
  output logic                                 alarmCodeLineA,
  output logic                                 alarmCodeLineB,
  output logic                                 alarmCodeLineC
);
  import dasm_pkg::*;

  localparam int NA = `DASM_NUM_ALARMS;
  localparam logic [NA-1:0] RESETTABLE = (NA'(1) << `DASM_AL_MAIN_DETECT) |
                                         (NA'(1) << `DASM_AL_CAPACITY) |
                                         (NA'(1) << `DASM_AL_SERVO_ON);
  // Parameter and setup alarms share the all-high code pattern
  localparam logic [NA-1:0] ALL_HIGH_SET = (NA'(1) << `DASM_AL_PARAM_CORRUPT) |
                                           (NA'(1) << `DASM_AL_MAIN_DETECT) |
                                           (NA'(1) << `DASM_AL_PARAM_RANGE) |
                                           (NA'(1) << `DASM_AL_ENC_OUT) |
                                           (NA'(1) << `DASM_AL_PARAM_COMBO) |
                                           (NA'(1) << `DASM_AL_CAPACITY) |
                                           (NA'(1) << `DASM_AL_UNSUPPORTED) |
                                           (NA'(1) << `DASM_AL_SCALE_PITCH) |
                                           (NA'(1) << `DASM_AL_SERVO_ON);

  // Three-stage synchronisers for pin inputs
  logic [2:0] keySync;
  logic [2:0] hb1Sync;
  logic [2:0] hb2Sync;
  logic [2:0] sonSync;
  logic [2:0] rstSync;
  logic [2:0] utilSync;
  logic       keyLevel;
  logic       hb1Level;
  logic       hb2Level;
  logic       sonLevel;
  logic       rstLevel;
  logic       utilLevel;
  logic       sonPrev;
  logic       rstPrev;

  always_ff @(posedge mclk) begin
    if (srst) begin
      keySync  <= 3'h0;
      hb1Sync  <= 3'h0;
      hb2Sync  <= 3'h0;
      sonSync  <= 3'h0;
      rstSync  <= 3'h0;
      utilSync <= 3'h0;
    end else begin
      keySync  <= {keySync[1:0], dataShiftKey};
      hb1Sync  <= {hb1Sync[1:0], safetyBlockInputOne};
      hb2Sync  <= {hb2Sync[1:0], safetyBlockInputTwo};
      sonSync  <= {sonSync[1:0], servoOnRequest};
      rstSync  <= {rstSync[1:0], alarmResetRequest};
      utilSync <= {utilSync[1:0], utilityEnergized};
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      keyLevel  <= 1'b0;
      hb1Level  <= 1'b0;
      hb2Level  <= 1'b0;
      sonLevel  <= 1'b0;
      rstLevel  <= 1'b0;
      utilLevel <= 1'b0;
    end else begin
      if (keySync[1] == keySync[2]) keyLevel <= keySync[2];
      if (hb1Sync[1] == hb1Sync[2]) hb1Level <= hb1Sync[2];
      if (hb2Sync[1] == hb2Sync[2]) hb2Level <= hb2Sync[2];
      if (sonSync[1] == sonSync[2]) sonLevel <= sonSync[2];
      if (rstSync[1] == rstSync[2]) rstLevel <= rstSync[2];
      if (utilSync[1] == utilSync[2]) utilLevel <= utilSync[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sonPrev <= 1'b0;
      rstPrev <= 1'b0;
    end else begin
      sonPrev <= sonLevel;
      rstPrev <= rstLevel;
    end
  end

  wire logic servoOnEdge = sonLevel & ~sonPrev;
  wire logic resetEdge   = rstLevel & ~rstPrev;

  // Registers
  logic        swReset;
  logic        forceControl;
  logic [11:0] powerOnSelect;
  logic [1:0]  groupOneStopSelect;
  logic [1:0]  groupTwoStopSelect;
  logic [1:0]  groupTwoMethod;
  logic        rdValid;

  // Panel display state
  logic [31:0] holdCount;
  logic        keyHandled;
  logic        ponApplied;

  // Alarms
  logic [NA-1:0] alarmLatched;
  logic [NA-1:0] alarmCauseAll;

  function automatic logic [2:0] alarm_code(input logic [NA-1:0] al);
    logic [2:0] code;
    code = `DASM_CODE_NONE;
    if (al[`DASM_AL_OVERCURRENT]) code = `DASM_CODE_OVERCURRENT;
    if (|(al & ALL_HIGH_SET)) code = `DASM_CODE_ALL_HIGH;
    return code;
  endfunction

  function automatic logic [6:0] seg_for(input logic on);
    return on ? `DASM_SEG_TOP : `DASM_SEG_BOTTOM;
  endfunction

  // Reads take one wait state so readdata stands when waitrequest drops
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= avs_read && !rdValid;
    end
  end

  assign avs_waitrequest = avs_read && !rdValid;

  always_ff @(posedge mclk) begin
    if (srst) begin
      forceControl       <= 1'b0;
      powerOnSelect      <= `DASM_PON_SEL_RESET;
      groupOneStopSelect <= 2'h0;
      groupTwoStopSelect <= 2'h0;
    end else if (avs_write) begin
      case (avs_address)
        `DASM_REG_CTRL: begin
          forceControl <= avs_writedata[`DASM_CTRL_FORCE_BIT];
        end
        `DASM_REG_PARAM: begin
          powerOnSelect      <= avs_writedata[11:0];
          groupOneStopSelect <= avs_writedata[17:16];
          groupTwoStopSelect <= avs_writedata[21:20];
        end
        default: begin
        end
      endcase
    end
  end

  // Software alarm reset pulse
  always_ff @(posedge mclk) begin
    if (srst) begin
      swReset <= 1'b0;
    end else begin
      swReset <= avs_write && avs_address == `DASM_REG_CTRL && avs_writedata[`DASM_CTRL_RESET_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !rdValid) begin
      case (avs_address)
        `DASM_REG_CTRL:   avs_readdata <= {30'h0, forceControl, 1'b0};
        `DASM_REG_PARAM:  avs_readdata <= {10'h0, groupTwoStopSelect, 2'h0, groupOneStopSelect, 4'h0, powerOnSelect};
        `DASM_REG_STATUS: avs_readdata <= {8'h0, groupTwoMethod, displayMode, stopGroup, alarmActive,
                                           alarmCodeLineA, alarmCodeLineB, alarmCodeLineC, 4'h0, alarmLatched};
        `DASM_REG_DISP:   avs_readdata <= {18'h0, hb2Level, hb1Level, displayItem};
        default:          avs_readdata <= 32'h0;
      endcase
    end
  end

  // Key hold timer: one second press toggles safety monitor
  always_ff @(posedge mclk) begin
    if (srst) begin
      holdCount  <= 32'h0;
      keyHandled <= 1'b0;
    end else if (!keyLevel) begin
      holdCount  <= 32'h0;
      keyHandled <= 1'b0;
    end else if (!keyHandled) begin
      if (holdCount >= 32'(HOLD_CYCLES - 1)) begin
        keyHandled <= 1'b1;
      end else begin
        holdCount <= holdCount + 32'h1;
      end
    end
  end

  wire logic keyLongPress = keyLevel && !keyHandled && holdCount >= 32'(HOLD_CYCLES - 1);

  // Display mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      displayMode <= DASM_DISP_STATUS;
      displayItem <= 12'h0;
      ponApplied  <= 1'b0;
    end else if (!ponApplied) begin
      ponApplied  <= 1'b1;
      displayItem <= powerOnSelect;
      if (powerOnSelect == `DASM_PON_SEL_STATUS) begin
        displayMode <= DASM_DISP_STATUS;
      end else if (powerOnSelect == `DASM_SAFETY_ITEM) begin
        displayMode <= DASM_DISP_SAFETY;
      end else begin
        displayMode <= DASM_DISP_ITEM;
      end
    end else if (avs_write && avs_address == `DASM_REG_DISP) begin
      displayItem <= avs_writedata[11:0];
      displayMode <= DASM_DISP_ITEM;
    end else if (avs_write && avs_address == `DASM_REG_PARAM) begin
      // A new power-on selection takes effect without a restart
      ponApplied <= 1'b0;
    end else if (keyLongPress) begin
      case (displayMode)
        DASM_DISP_SAFETY: displayMode <= DASM_DISP_ITEM;
        DASM_DISP_ITEM: begin
          if (displayItem == `DASM_SAFETY_ITEM) displayMode <= DASM_DISP_SAFETY;
        end
        default: displayMode <= displayMode;
      endcase
    end
  end

  // Segment drive: digit 1 is segments[6:0]
  always_ff @(posedge mclk) begin
    if (srst) begin
      segments <= 56'h0;
    end else if (displayMode == DASM_DISP_SAFETY) begin
      segments <= {42'h0, seg_for(hb2Level), seg_for(hb1Level)};
    end else begin
      segments <= 56'h0;
    end
  end

  // Alarm latching
  always_comb begin
    alarmCauseAll = alarmCause;
    alarmCauseAll[`DASM_AL_SCALE_PITCH] = alarmCause[`DASM_AL_SCALE_PITCH] | scalePitchDefault;
    alarmCauseAll[`DASM_AL_SERVO_ON] = alarmCause[`DASM_AL_SERVO_ON] | (servoOnEdge & utilLevel);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      alarmLatched <= '0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        if (alarmCauseAll[i]) begin
          alarmLatched[i] <= 1'b1; // Set wins over reset
        end else if ((resetEdge || swReset) && RESETTABLE[i]) begin
          alarmLatched[i] <= 1'b0;
        end
      end
    end
  end

  // Code lines hold the latched code while the alarm stands
  always_ff @(posedge mclk) begin
    if (srst) begin
      {alarmCodeLineA, alarmCodeLineB, alarmCodeLineC} <= `DASM_CODE_NONE;
      alarmActive <= 1'b0;
    end else begin
      {alarmCodeLineA, alarmCodeLineB, alarmCodeLineC} <= alarm_code(alarmLatched);
      alarmActive <= |alarmLatched;
    end
  end

  // All listed alarms belong to group one
  always_ff @(posedge mclk) begin
    if (srst) begin
      stopGroup  <= DASM_STOP_NONE;
      stopMethod <= 2'h0;
    end else if (|alarmLatched) begin
      stopGroup  <= DASM_STOP_G1;
      stopMethod <= groupOneStopSelect;
    end else begin
      stopGroup  <= DASM_STOP_NONE;
      stopMethod <= 2'h0;
    end
  end

  // Group-two stop resolution, reported in the status word
  always_comb begin
    if (forceControl || groupTwoStopSelect == `DASM_G2_SAME_AS_G1) begin
      groupTwoMethod = groupOneStopSelect;
    end else begin
      groupTwoMethod = groupTwoStopSelect;
    end
  end
endmodule // dasm_monitor

// *** tb/dasm_monitor_assertions.sv ***
`timescale 1ns/1ps
`include "dasm_consts.svh"
module dasm_monitor_chk (
  input wire logic                        mclk,
  input wire logic                        srst,
  input wire logic                        safetyBlockInputOne,
  input wire logic                        safetyBlockInputTwo,
  input wire logic                        servoOnRequest,
  input wire logic                        utilityEnergized,
  input wire logic [`DASM_NUM_ALARMS-1:0] alarmCause,
  input wire logic                        scalePitchDefault,
  input wire dasm_pkg::dasm_disp_type     displayMode,
  input wire logic [55:0]                 segments,
  input wire dasm_pkg::dasm_stop_type     stopGroup,
  input wire logic                        alarmActive,
  input wire logic                        alarmCodeLineA,
  input wire logic                        alarmCodeLineB,
  input wire logic                        alarmCodeLineC
);
  import dasm_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic [2:0] code;
  assign code = {alarmCodeLineA, alarmCodeLineB, alarmCodeLineC};
  // Safety view shown and the pin settled long enough to pass the synchroniser
  sequence s_show(pin);
    (displayMode == DASM_DISP_SAFETY && pin)[*8];
  endsequence
  sequence s_servo_late;
    $rose(servoOnRequest) && utilityEnergized ##1 (servoOnRequest && utilityEnergized)[*7];
  endsequence
  a_top_on_lit: assert property (s_show(safetyBlockInputOne) |-> segments[0] && !segments[3])
    else $error("Digit one top segment wrong");
  a_bottom_off_lit: assert property (s_show(!safetyBlockInputOne) |-> segments[3] && !segments[0])
    else $error("Digit one bottom segment wrong");
  a_digit_two_map: assert property (s_show(safetyBlockInputTwo) |-> segments[7] && !segments[10])
    else $error("Digit two does not follow input two");
  a_reserved_dark: assert property ($past(displayMode) == DASM_DISP_SAFETY && displayMode == DASM_DISP_SAFETY
    |-> segments[55:14] == '0) else $error("Reserved digit lit");
  a_stop_group_one: assert property (alarmActive |-> stopGroup == DASM_STOP_G1)
    else $error("Active alarm without group one stop");
  a_code_idle: assert property (!alarmActive |-> code == 3'h0)
    else $error("Code lines set with no alarm");
  a_corrupt_code: assert property (alarmCause[0] |-> ##[1:4] alarmActive && code == 3'h7)
    else $error("Corruption alarm code wrong");
  a_overcurrent_code: assert property (alarmCause[9] |-> ##[1:4] alarmActive && code[1:0] == 2'h3)
    else $error("Overcurrent alarm code wrong");
  a_servo_late_alarm: assert property (s_servo_late |-> alarmActive)
    else $error("Late servo-on raised no alarm");
  a_scale_pitch_alarm: assert property (scalePitchDefault |-> ##[1:4] alarmActive)
    else $error("Default scale pitch raised no alarm");
endmodule // dasm_monitor_chk
bind dasm_monitor dasm_monitor_chk chk (.mclk, .srst, .safetyBlockInputOne, .safetyBlockInputTwo,
  .servoOnRequest, .utilityEnergized, .alarmCause, .scalePitchDefault, .displayMode, .segments,
  .stopGroup, .alarmActive, .alarmCodeLineA, .alarmCodeLineB, .alarmCodeLineC);

// *** tb/dasm_host_model.sv ***
`timescale 1ns/1ps
module dasm_host_model (
  input  wire logic mclk,
  output logic      dataShiftKey,
  output logic      safetyBlockInputOne,
  output logic      safetyBlockInputTwo,
  output logic      servoOnRequest,
  output logic      alarmResetRequest,
  output logic      utilityEnergized
);
  initial begin
    dataShiftKey = 1'b0;
    safetyBlockInputOne = 1'b0;
    safetyBlockInputTwo = 1'b0;
    servoOnRequest = 1'b0;
    alarmResetRequest = 1'b0;
    utilityEnergized = 1'b0;
  end
  task automatic holdKey(input int n);
    dataShiftKey <= 1'b1;
    repeat (n) @(posedge mclk);
    dataShiftKey <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // Shorted circuit drives high
  task automatic setSafety(input logic one, input logic two);
    safetyBlockInputOne <= one;
    safetyBlockInputTwo <= two;
  endtask
  // Only called once the alarm cause is gone
  task automatic pinReset;
    alarmResetRequest <= 1'b1;
    repeat (6) @(posedge mclk);
    alarmResetRequest <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Deliberate misuse: servo-on while a utility drives the motor
  task automatic servoAfterUtility;
    utilityEnergized <= 1'b1;
    repeat (8) @(posedge mclk);
    servoOnRequest <= 1'b1;
    repeat (12) @(posedge mclk);
    servoOnRequest <= 1'b0;
    utilityEnergized <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule // dasm_host_model

// *** tb/test_drive_alarm_and_safety_monitor.sv ***
`timescale 1ns/1ps
`include "dasm_consts.svh"
module test_drive_alarm_and_safety_monitor;
  import dasm_pkg::*;
  logic                        mclk = 1'b0;
  logic                        srst = 1'b1;
  logic                        avs_read = 1'b0;
  logic                        avs_write = 1'b0;
  logic [3:0]                  avs_address = 4'h0;
  logic [31:0]                 avs_writedata = 32'h0;
  logic [31:0]                 avs_readdata;
  logic [31:0]                 rd;
  logic                        avs_waitrequest;
  logic [`DASM_NUM_ALARMS-1:0] alarmCause = '0;
  logic                        scalePitchDefault = 1'b0;
  logic                        dataShiftKey, safetyBlockInputOne, safetyBlockInputTwo;
  logic                        servoOnRequest, alarmResetRequest, utilityEnergized;
  dasm_disp_type               displayMode;
  logic [11:0]                 displayItem;
  logic [55:0]                 segments;
  dasm_stop_type               stopGroup;
  logic [1:0]                  stopMethod;
  logic                        alarmActive, alarmCodeLineA, alarmCodeLineB, alarmCodeLineC;
  logic [2:0]                  cd;
  int                          failures = 0;
  int                          checkCount = 0;
  always #25 mclk = ~mclk;
  dasm_monitor #(.HOLD_CYCLES(8)) DUT (.mclk, .srst, .avs_read, .avs_write, .avs_address, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .dataShiftKey, .safetyBlockInputOne, .safetyBlockInputTwo,
    .servoOnRequest, .alarmResetRequest, .utilityEnergized, .alarmCause, .scalePitchDefault, .displayMode,
    .displayItem, .segments, .stopGroup, .stopMethod, .alarmActive, .alarmCodeLineA, .alarmCodeLineB,
    .alarmCodeLineC);
  dasm_host_model host (.mclk, .dataShiftKey, .safetyBlockInputOne, .safetyBlockInputTwo,
    .servoOnRequest, .alarmResetRequest, .utilityEnergized);
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input logic [55:0] got, input logic [55:0] exp, input string what);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask
  task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
  endtask
  // Read data are taken at the edge where waitrequest is seen low
  task automatic busRead(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_read <= 1'b1;
    avs_address <= a;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic doReset;
    @(posedge mclk);
    srst <= 1'b1;
    tick(6);
    srst <= 1'b0;
    tick(2);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    doReset();
    check(displayMode, DASM_DISP_STATUS, "status mode at power-up");
    busRead(`DASM_REG_PARAM, rd);
    check(rd[11:0], 12'hfff, "power-on select reset value");
    for (int i = 0; i < 2; i++) begin
      busWrite(`DASM_REG_PARAM, i ? 32'h0012_0fff : 32'h0012_0000);
      busRead(`DASM_REG_PARAM, rd);
      check(rd[11:0], i ? 12'hfff : 12'h000, "power-on select range end");
      check(stopMethod, 2'h0, "no stop method without alarm");
      check(displayMode, i ? DASM_DISP_STATUS : DASM_DISP_ITEM, "power-on selection applied");
      check(displayItem, i ? 12'hfff : 12'h000, "power-on monitor item");
    end
    busRead(`DASM_REG_STATUS, rd);
    check(rd[23:22], 2'h2, "group two copies group one");
    busWrite(`DASM_REG_PARAM, 32'h0023_0fff);
    busRead(`DASM_REG_STATUS, rd);
    check(rd[23:22], 2'h2, "group two own selection");
    busWrite(`DASM_REG_CTRL, 32'h2);
    busRead(`DASM_REG_STATUS, rd);
    check(rd[23:22], 2'h3, "force control uses group one");
    alarmCause[1] <= 1'b1;
    tick(3);
    alarmCause[1] <= 1'b0;
    tick(6);
    check(stopMethod, 2'h3, "group-one stop selection");
    busWrite(`DASM_REG_CTRL, 32'h1);
    tick(8);
    check(alarmActive, 1'b0, "main detector alarm cleared");
    busWrite(`DASM_REG_DISP, {20'h0, `DASM_SAFETY_ITEM});
    host.holdKey(12);
    for (int i = 0; i < 4; i++) begin
      host.setSafety(i[0], i[1]);
      tick(10);
      check(displayMode, DASM_DISP_SAFETY, "safety view");
      check(segments, {42'h0, i[1] ? 7'h01 : 7'h08, i[0] ? 7'h01 : 7'h08}, "safety segments");
    end
    for (int c = 0; c < 10; c++) begin
      if (c == 7 || c == 8) continue;
      doReset();
      alarmCause[c] <= 1'b1;
      tick(3);
      alarmCause[c] <= 1'b0;
      tick(6);
      cd = (c == 9) ? 3'h3 : 3'h7;
      check(alarmActive, 1'b1, "alarm raised");
      check(stopGroup, DASM_STOP_G1, "group one stop");
      check({alarmCodeLineA, alarmCodeLineB, alarmCodeLineC}, cd, "alarm code lines");
      if (c == 5) host.pinReset();
      else busWrite(`DASM_REG_CTRL, 32'h1);
      tick(8);
      if (c == 1 || c == 5) cd = 3'h0;
      check(alarmActive, cd != 3'h0, "alarm after reset request");
      check({alarmCodeLineA, alarmCodeLineB, alarmCodeLineC}, cd, "code lines after reset");
    end
    doReset();
    host.servoAfterUtility();
    check(alarmActive, 1'b1, "late servo-on alarm");
    busRead(`DASM_REG_STATUS, rd);
    check(rd[8], 1'b1, "late servo-on alarm latched");
    host.pinReset();
    tick(8);
    check(alarmActive, 1'b0, "late servo-on alarm cleared");
    doReset();
    scalePitchDefault <= 1'b1;
    tick(3);
    scalePitchDefault <= 1'b0;
    busWrite(`DASM_REG_CTRL, 32'h1);
    tick(6);
    check(alarmActive, 1'b1, "scale pitch alarm held");
    report_and_stop();
  end
  initial begin
    tick(20000);
    failures++;
    $display("ERROR at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule // test_drive_alarm_and_safety_monitor
